// ==== rtl/bru_defines.svh ====
// Purpose: Constants for the byte rotate unit
// Assumes: 8-bit data memory bytes
// Notes: Opcode codes are local to this unit
`ifndef BRU_DEFINES_SVH
`define BRU_DEFINES_SVH
`define BRU_DATA_W 8
`define BRU_ADDR_W 8
`define BRU_MSB 7
`define BRU_LSB 0
`define BRU_OP_W 3
`define BRU_OP_RL 3'h0
`define BRU_OP_RLA 3'h1
`define BRU_OP_RLC 3'h2
`define BRU_OP_RLCA 3'h3
`define BRU_OP_RR 3'h4
`define BRU_MEM_WORDS 256
`define BRU_CARRY_RST 1'h0
`define BRU_ACC_RST 8'h00
`endif

// ==== rtl/bru_pkg.sv ====
// Purpose: Types for the byte rotate unit
// Assumes: bru_defines.svh is on the include path
// Notes: None
`include "bru_defines.svh"
`default_nettype none
package bru_pkg;
    typedef enum logic [`BRU_OP_W-1:0] {
        ROTATE_LEFT_IN_PLACE = 3'h0,
        ROTATE_LEFT_TO_ACCUMULATOR = 3'h1,
        ROTATE_LEFT_THROUGH_CARRY = 3'h2,
        ROTATE_LEFT_CARRY_TO_ACCUMULATOR = 3'h3,
        ROTATE_RIGHT_IN_PLACE = 3'h4
    } bru_op_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_READ = 2'h1,
        ST_WRITE = 2'h2
    } bru_state_t;
endpackage
`default_nettype wire

// ==== rtl/bru_rotator.sv ====
// Purpose: Combinational one-bit rotate of a byte
// Assumes: Operation code from bru_pkg
// Notes: Pure logic, no state
`include "bru_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module bru_rotator (
    input wire bru_pkg::bru_op_t op,
    input wire logic [`BRU_DATA_W-1:0] operand,
    input wire logic carryIn,
    output logic [`BRU_DATA_W-1:0] result,
    output logic carryOut,
    output logic toAcc,
    output logic usesCarry
);
    always_comb
    begin
        result = operand;
        carryOut = carryIn;
        toAcc = 1'h0;
        usesCarry = 1'h0;
        case (op)
            bru_pkg::ROTATE_LEFT_IN_PLACE:
            begin
                result = {operand[`BRU_MSB-1:0], operand[`BRU_MSB]};
            end
            bru_pkg::ROTATE_LEFT_TO_ACCUMULATOR:
            begin
                result = {operand[`BRU_MSB-1:0], operand[`BRU_MSB]};
                toAcc = 1'h1;
            end
            bru_pkg::ROTATE_LEFT_THROUGH_CARRY:
            begin
                result = {operand[`BRU_MSB-1:0], carryIn};
                carryOut = operand[`BRU_MSB];
                usesCarry = 1'h1;
            end
            bru_pkg::ROTATE_LEFT_CARRY_TO_ACCUMULATOR:
            begin
                result = {operand[`BRU_MSB-1:0], carryIn};
                carryOut = operand[`BRU_MSB];
                toAcc = 1'h1;
                usesCarry = 1'h1;
            end
            bru_pkg::ROTATE_RIGHT_IN_PLACE:
            begin
                result = {operand[`BRU_LSB], operand[`BRU_MSB:1]};
            end
            default:
            begin
                result = operand;
            end
        endcase
    end
endmodule
`default_nettype wire

// ==== rtl/bru_byte_rotate_unit.sv ====
// Purpose: Executes one-bit rotate instructions on a data memory byte
// Assumes: Core supplies opcode and byte address with a start pulse
// Notes: Owns its data memory; backdoor port lets the core load bytes
`include "bru_defines.svh"
`timescale 1ns/1ns
`default_nettype none
// How it works
// - left rotate in place, bit 7 wraps to bit 0, written back
// - left rotate into accumulator, memory byte untouched
// - left through carry: old carry into bit 0, bit 7 to carry
// - left through carry into accumulator; bit 7 to carry, memory kept
// - right rotate in place, bit 0 wraps to bit 7, written back
// - only through-carry rotates touch carry; other flags never change
module bru_byte_rotate_unit (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [`BRU_OP_W-1:0] opcode,
    input wire logic [`BRU_ADDR_W-1:0] memAddr,
    input wire logic loadWe,
    input wire logic [`BRU_ADDR_W-1:0] loadAddr,
    input wire logic [`BRU_DATA_W-1:0] loadData,
    input wire logic [`BRU_ADDR_W-1:0] peekAddr,
    output logic [`BRU_DATA_W-1:0] peekData,
    output logic [`BRU_DATA_W-1:0] accOut,
    output logic carryOut,
    output logic busy,
    output logic done
);
    logic rstMeta_r;
    logic rstSync_r;
    logic [`BRU_DATA_W-1:0] mem [`BRU_MEM_WORDS];
    bru_pkg::bru_state_t state_r, state_nxt;
    bru_pkg::bru_op_t op_r, op_nxt;
    logic [`BRU_ADDR_W-1:0] addr_r, addr_nxt;
    logic [`BRU_DATA_W-1:0] operand_r, operand_nxt;
    logic [`BRU_DATA_W-1:0] acc_r, acc_nxt;
    logic carry_r, carry_nxt;
    logic done_r, done_nxt;
    logic [`BRU_DATA_W-1:0] peek_r;
    logic [`BRU_DATA_W-1:0] rotResult;
    logic rotCarry;
    logic rotToAcc;
    logic rotUsesCarry;
    logic memWe;

    // Reset release is synchronised so every flop reset by rstSync_r leaves reset together
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstMeta_r <= 1'h0;
            rstSync_r <= 1'h0;
        end
        else
        begin
            rstMeta_r <= 1'h1;
            rstSync_r <= rstMeta_r;
        end
    end

    bru_rotator bru_rotator_i (
        .op(op_r),
        .operand(operand_r),
        .carryIn(carry_r),
        .result(rotResult),
        .carryOut(rotCarry),
        .toAcc(rotToAcc),
        .usesCarry(rotUsesCarry)
    );

    function automatic logic opLegal(input logic [`BRU_OP_W-1:0] code);
        opLegal = (code <= `BRU_OP_RR);
    endfunction

    always_comb
    begin
        state_nxt = state_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        operand_nxt = operand_r;
        acc_nxt = acc_r;
        carry_nxt = carry_r;
        done_nxt = 1'h0;
        memWe = 1'h0;
        case (state_r)
            bru_pkg::ST_IDLE:
            begin
                // Illegal opcodes are dropped silently
                if (start && opLegal(opcode))
                begin
                    op_nxt = bru_pkg::bru_op_t'(opcode);
                    addr_nxt = memAddr;
                    state_nxt = bru_pkg::ST_READ;
                end
            end
            bru_pkg::ST_READ:
            begin
                operand_nxt = mem[addr_r];
                state_nxt = bru_pkg::ST_WRITE;
            end
            bru_pkg::ST_WRITE:
            begin
                if (rotToAcc)
                begin
                    acc_nxt = rotResult;
                end
                else
                begin
                    memWe = 1'h1;
                end
                if (rotUsesCarry)
                begin
                    carry_nxt = rotCarry;
                end
                done_nxt = 1'h1;
                state_nxt = bru_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt = bru_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            state_r <= bru_pkg::ST_IDLE;
            op_r <= bru_pkg::ROTATE_LEFT_IN_PLACE;
            addr_r <= 8'h00;
            operand_r <= 8'h00;
            acc_r <= `BRU_ACC_RST;
            carry_r <= `BRU_CARRY_RST;
            done_r <= 1'h0;
        end
        else
        begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            operand_r <= operand_nxt;
            acc_r <= acc_nxt;
            carry_r <= carry_nxt;
            done_r <= done_nxt;
        end
    end

    // Memory has no reset; rotate write wins over a same-cycle load
    always_ff @(posedge clock)
    begin
        if (memWe)
        begin
            mem[addr_r] <= rotResult;
        end
        else if (loadWe)
        begin
            mem[loadAddr] <= loadData;
        end
    end

    always_ff @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            peek_r <= 8'h00;
        end
        else
        begin
            peek_r <= mem[peekAddr];
        end
    end

    assign peekData = peek_r;
    assign accOut = acc_r;
    assign carryOut = carry_r;
    assign done = done_r;
    assign busy = (state_r != bru_pkg::ST_IDLE);

    property p_rl;
        @(posedge clock) disable iff (!rstSync_r)
        (state_r == bru_pkg::ST_WRITE && op_r == bru_pkg::ROTATE_LEFT_IN_PLACE)
        |=> mem[$past(addr_r)] == {$past(operand_r[6:0]), $past(operand_r[7])};
    endproperty
    a_rl: assert property (p_rl) else $error("left rotate bad");

    property p_rla;
        @(posedge clock) disable iff (!rstSync_r)
        (state_r == bru_pkg::ST_WRITE
            && op_r == bru_pkg::ROTATE_LEFT_TO_ACCUMULATOR)
        |=> acc_r == {$past(operand_r[6:0]), $past(operand_r[7])}
            && mem[$past(addr_r)] == $past(operand_r);
    endproperty
    a_rla: assert property (p_rla)
        else $error("acc rotate bad");

    property p_rlc;
        @(posedge clock) disable iff (!rstSync_r)
        (state_r == bru_pkg::ST_WRITE
            && op_r == bru_pkg::ROTATE_LEFT_THROUGH_CARRY)
        |=> mem[$past(addr_r)] == {$past(operand_r[6:0]), $past(carry_r)}
            && carry_r == $past(operand_r[7]);
    endproperty
    a_rlc: assert property (p_rlc)
        else $error("carry rotate bad");

    property p_rlca;
        @(posedge clock) disable iff (!rstSync_r)
        (state_r == bru_pkg::ST_WRITE
            && op_r == bru_pkg::ROTATE_LEFT_CARRY_TO_ACCUMULATOR)
        |=> acc_r == {$past(operand_r[6:0]), $past(carry_r)}
            && carry_r == $past(operand_r[7])
            && mem[$past(addr_r)] == $past(operand_r);
    endproperty
    a_rlca: assert property (p_rlca)
        else $error("carry acc bad");

    property p_rr;
        @(posedge clock) disable iff (!rstSync_r)
        (state_r == bru_pkg::ST_WRITE
            && op_r == bru_pkg::ROTATE_RIGHT_IN_PLACE)
        |=> mem[$past(addr_r)] == {$past(operand_r[0]), $past(operand_r[7:1])};
    endproperty
    a_rr: assert property (p_rr)
        else $error("right rotate bad");

    property p_flags;
        @(posedge clock) disable iff (!rstSync_r)
        !(state_r == bru_pkg::ST_WRITE && rotUsesCarry) |=> $stable(carry_r);
    endproperty
    a_flags: assert property (p_flags)
        else $error("carry moved");

    property p_seq;
        @(posedge clock) disable iff (!rstSync_r)
        (state_r == bru_pkg::ST_IDLE && start && opLegal(opcode))
        |=> busy ##1 busy ##1 done && !busy;
    endproperty
    a_seq: assert property (p_seq) else $error("sequence bad");

    property p_accHold;
        @(posedge clock) disable iff (!rstSync_r)
        !(state_r == bru_pkg::ST_WRITE && rotToAcc) |=> $stable(acc_r);
    endproperty
    a_accHold: assert property (p_accHold)
        else $error("acc moved");

    c_rlc: cover property (@(posedge clock) disable iff (!rstSync_r)
        state_r == bru_pkg::ST_WRITE
        && op_r == bru_pkg::ROTATE_LEFT_THROUGH_CARRY);
    c_rlca: cover property (@(posedge clock) disable iff (!rstSync_r)
        state_r == bru_pkg::ST_WRITE && rotToAcc && rotUsesCarry);
    c_rr: cover property (@(posedge clock) disable iff (!rstSync_r)
        state_r == bru_pkg::ST_WRITE
        && op_r == bru_pkg::ROTATE_RIGHT_IN_PLACE);
endmodule
`default_nettype wire

// ==== verification/byte_rotate_unit_tb.sv ====
// Purpose: Self-checking bench for the byte rotate unit
// Assumes: Inputs change 1 ns after the rising edge; memory loaded first
// Notes: Expected results come from a bench-side rotate model
`include "bru_defines.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
    begin \
        nChecks++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("Error at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module byte_rotate_unit_tb;
    logic clock;
    logic arst_n;
    logic start;
    logic [`BRU_OP_W-1:0] opcode;
    logic [`BRU_ADDR_W-1:0] memAddr;
    logic loadWe;
    logic [`BRU_ADDR_W-1:0] loadAddr;
    logic [`BRU_DATA_W-1:0] loadData;
    logic [`BRU_ADDR_W-1:0] peekAddr;
    logic [`BRU_DATA_W-1:0] peekData;
    logic [`BRU_DATA_W-1:0] accOut;
    logic carryOut;
    logic busy;
    logic done;
    logic [`BRU_DATA_W-1:0] expAcc;
    logic [`BRU_DATA_W-1:0] expMem;
    logic [`BRU_DATA_W-1:0] gotMem;
    logic expC;
    int gotLat;
    int mismatches = 0;
    int nChecks = 0;
    int cycles = 0;

    bru_byte_rotate_unit bru_byte_rotate_unit_i (
        .clock(clock), .arst_n(arst_n), .start(start), .opcode(opcode),
        .memAddr(memAddr), .loadWe(loadWe), .loadAddr(loadAddr),
        .loadData(loadData), .peekAddr(peekAddr), .peekData(peekData),
        .accOut(accOut), .carryOut(carryOut), .busy(busy), .done(done)
    );

    initial
    begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    // Whole run needs under 100 cycles; the ceiling leaves wide margin
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            $display("Error at %0t: timeout got %h expected %h", $time,
                     cycles, 2000);
            final_report();
        end
    end

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic step();
        @(posedge clock);
        #1;
    endtask

    // Returns {carry, result}
    function automatic logic [8:0] model(input logic [2:0] op,
                                         input logic [7:0] d, input logic c);
        case (op)
            bru_pkg::ROTATE_LEFT_IN_PLACE,
            bru_pkg::ROTATE_LEFT_TO_ACCUMULATOR: return {c, d[6:0], d[7]};
            bru_pkg::ROTATE_LEFT_THROUGH_CARRY,
            bru_pkg::ROTATE_LEFT_CARRY_TO_ACCUMULATOR: return {d, c};
            default: return {c, d[0], d[7:1]};
        endcase
    endfunction

    task automatic load(input logic [7:0] a, input logic [7:0] d);
        loadWe = 1'h1;
        loadAddr = a;
        loadData = d;
        step();
        loadWe = 1'h0;
    endtask

    task automatic peek(input logic [7:0] a, output logic [7:0] d);
        peekAddr = a;
        step();
        d = peekData;
    endtask

    // Ends in the cycle done shows, or after 8 cycles without it
    task automatic run(input logic [2:0] op, input logic [7:0] a,
                       output int lat);
        start = 1'h1;
        opcode = op;
        memAddr = a;
        step();
        start = 1'h0;
        lat = 0;
        while (done !== 1'h1 && lat < 8)
        begin
            step();
            lat++;
        end
    endtask

    task automatic one(input bru_pkg::bru_op_t op, input logic [7:0] a,
                       input logic [7:0] d);
        logic [8:0] r;
        r = model(op, d, expC);
        expMem = d;
        if (op == bru_pkg::ROTATE_LEFT_TO_ACCUMULATOR ||
            op == bru_pkg::ROTATE_LEFT_CARRY_TO_ACCUMULATOR)
            expAcc = r[7:0];
        else
            expMem = r[7:0];
        expC = r[8];
        load(a, d);
        run(op, a, gotLat);
        peek(a, gotMem);
    endtask

    task automatic t_rlc();
        one(bru_pkg::ROTATE_LEFT_THROUGH_CARRY, 8'h11, 8'h80);
        `CHK(gotMem, expMem)
        `CHK(carryOut, expC)
        one(bru_pkg::ROTATE_LEFT_THROUGH_CARRY, 8'h12, 8'h41);
        `CHK(gotMem, expMem)
        `CHK(carryOut, expC)
        `CHK(accOut, expAcc)
        `CHK(gotLat, 2)
        $display("Test rotate_left_through_carry finished");
    endtask

    task automatic t_rlca();
        one(bru_pkg::ROTATE_LEFT_CARRY_TO_ACCUMULATOR, 8'h13, 8'hC1);
        `CHK(accOut, expAcc)
        `CHK(carryOut, expC)
        `CHK(gotMem, expMem)
        one(bru_pkg::ROTATE_LEFT_CARRY_TO_ACCUMULATOR, 8'hFF, 8'hA0);
        `CHK(accOut, expAcc)
        `CHK(carryOut, expC)
        `CHK(gotMem, expMem)
        $display("Test rotate_left_carry_to_accumulator finished");
    endtask

    // Carry is 1 here, as is bit 7 of the byte, so a plain rotate that leaks carry gives the same result
    task automatic t_rl();
        one(bru_pkg::ROTATE_LEFT_IN_PLACE, 8'h00, 8'h81);
        `CHK(gotMem, expMem)
        `CHK(accOut, expAcc)
        `CHK(carryOut, expC)
        $display("Test rotate_left_in_place finished");
    endtask

    task automatic t_rla();
        one(bru_pkg::ROTATE_LEFT_TO_ACCUMULATOR, 8'h14, 8'h96);
        `CHK(accOut, expAcc)
        `CHK(gotMem, expMem)
        `CHK(carryOut, expC)
        $display("Test rotate_left_to_accumulator finished");
    endtask

    task automatic t_rr();
        one(bru_pkg::ROTATE_RIGHT_IN_PLACE, 8'h15, 8'h01);
        `CHK(gotMem, expMem)
        `CHK(accOut, expAcc)
        `CHK(carryOut, expC)
        $display("Test rotate_right_in_place finished");
    endtask

    task automatic t_bad();
        load(8'h30, 8'h5A);
        for (int op = 5; op < 8; op++)
        begin
            run(op[2:0], 8'h30, gotLat);
            `CHK(gotLat, 8)
        end
        peek(8'h30, gotMem);
        `CHK(gotMem, 8'h5A)
        `CHK(accOut, expAcc)
        `CHK(carryOut, expC)
        $display("Test unused opcodes finished");
    endtask

    // Start held high: taken again only in the done cycle, never while busy
    task automatic t_b2b();
        int n;
        int nb;
        load(8'h20, 8'h01);
        start = 1'h1;
        opcode = bru_pkg::ROTATE_LEFT_IN_PLACE;
        memAddr = 8'h20;
        n = 0;
        nb = 0;
        repeat (6)
        begin
            step();
            if (done === 1'h1)
                n++;
            if (busy === 1'h1)
                nb++;
        end
        start = 1'h0;
        `CHK(n, 2)
        `CHK(nb, 4)
        peek(8'h20, gotMem);
        `CHK(gotMem, 8'h04)
        $display("Test back to back finished");
    endtask

    initial
    begin
        arst_n = 1'h0;
        start = 1'h0;
        opcode = 3'h0;
        memAddr = 8'h00;
        loadWe = 1'h0;
        loadAddr = 8'h00;
        loadData = 8'h00;
        peekAddr = 8'h00;
        expAcc = 8'h00;
        expC = 1'h0;
        repeat (3) @(posedge clock);
        #1;
        arst_n = 1'h1;
        repeat (3) step();
        t_rlc();
        t_rlca();
        t_rl();
        t_rla();
        t_rr();
        t_bad();
        t_b2b();
        final_report();
    end
endmodule
`undef CHK
`default_nettype wire
